/* File: design/dsr_defines.svh */
`ifndef DSR_DEFINES_SVH
`define DSR_DEFINES_SVH

// ----------------------------------------------------------------
// Structure constants
// ----------------------------------------------------------------
`define DSR_STAGE_COUNT 8
`define DSR_CHAIN_COUNT 2
`define DSR_SYNC_DEPTH 2

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define DSR_STAGE_CLEAR 1'h0
`define DSR_CLOCK_SYNC_RESET 1'h1
`define DSR_DATA_SYNC_RESET 1'h0

`endif

/* File: design/dsr_pkg.sv */
`include "dsr_defines.svh"

package dsr_pkg;

   // ----------------------------------------------------------------
   // Shared types
   // ----------------------------------------------------------------
   typedef logic [`DSR_STAGE_COUNT-1:0] dsr_stage_t;
   typedef logic [`DSR_CHAIN_COUNT-1:0] dsr_chain_bits_t;
   typedef logic [`DSR_SYNC_DEPTH-1:0] dsr_sync_t;

   // Serial source choice, follows the select pin level
   typedef enum logic {
      DSR_SRC_A = 1'h0,
      DSR_SRC_B = 1'h1
   } dsr_src_t;

endpackage

/* File: design/dsr_chain_if.sv */
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------------------------------
// Link between the input front end and one shift chain
// ----------------------------------------------------------------
interface dsr_chain_if;
   logic shift_pulse;
   logic serial_input;
   logic last_stage_out;
   logic last_stage_out_n;

   modport feed (
      output shift_pulse,
      output serial_input,
      input last_stage_out,
      input last_stage_out_n
   );

   modport chain (
      input shift_pulse,
      input serial_input,
      output last_stage_out,
      output last_stage_out_n
   );
endinterface

`default_nettype wire

/* File: design/dsr_shift_chain.sv */
`timescale 1ns/100ps
`default_nettype none
`include "dsr_defines.svh"

module dsr_shift_chain
   import dsr_pkg::*;
#(
   parameter int STAGES = `DSR_STAGE_COUNT
) (
   input wire logic ref_clk_i, // System clock
   input wire logic clear_n_i, // Async clear, active low
   dsr_chain_if.chain link     // Shift pulse, serial data, outputs
);

   // ----------------------------------------------------------------
   // Stage storage
   // ----------------------------------------------------------------
   logic [STAGES-1:0] stages;
   logic stage_last_n;

   // All stages share one enable, so they move on the same event
   always_ff @(posedge ref_clk_i or negedge clear_n_i) begin
      if (!clear_n_i) begin
         stages <= '0;
      end else if (link.shift_pulse) begin
         stages <= {stages[STAGES-2:0], link.serial_input};
      end
   end

   // Complement kept in its own flop so both outputs are registered
   always_ff @(posedge ref_clk_i or negedge clear_n_i) begin
      if (!clear_n_i) begin
         stage_last_n <= ~`DSR_STAGE_CLEAR;
      end else if (link.shift_pulse) begin
         stage_last_n <= ~stages[STAGES-2];
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign link.last_stage_out = stages[STAGES-1];
   assign link.last_stage_out_n = stage_last_n;

endmodule

`default_nettype wire

/* File: design/dsr_dual_shift_top.sv */
`timescale 1ns/100ps
`default_nettype none
`include "dsr_defines.svh"

module dsr_dual_shift_top
   import dsr_pkg::*;
#(
   parameter int CHAINS = `DSR_CHAIN_COUNT,
   parameter int STAGES = `DSR_STAGE_COUNT
) (
   input wire logic ref_clk_i,                  // System clock, 100 MHz
   input wire logic reset_n_i,                  // Async system reset
   input wire logic clear_all_n_i,              // Pin: clear both registers
   input wire logic shared_shift_clock_i,       // Pin: clock shared by both
   input wire logic [CHAINS-1:0] shift_clock_i, // Pins: own clock per register
   input wire logic [CHAINS-1:0] source_select_i,   // Pins: serial source select
   input wire logic [CHAINS-1:0] serial_source_a_i, // Pins: source A data
   input wire logic [CHAINS-1:0] serial_source_b_i, // Pins: source B data
   output logic [CHAINS-1:0] last_stage_out_o,      // True last stage
   output logic [CHAINS-1:0] last_stage_out_n_o     // Inverted last stage
);

   // ----------------------------------------------------------------
   // Clear synchroniser
   // ----------------------------------------------------------------
   logic clear_raw_n;
   logic clear_meta_n;
   logic clear_sync_n;

   // One pin clears both chains; system reset joins it
   assign clear_raw_n = reset_n_i & clear_all_n_i;

   // Assert at once, release on the clock to avoid a torn release
   always_ff @(posedge ref_clk_i or negedge clear_raw_n) begin
      if (!clear_raw_n) begin
         clear_meta_n <= 1'h0;
         clear_sync_n <= 1'h0;
      end else begin
         clear_meta_n <= 1'h1;
         clear_sync_n <= clear_meta_n;
      end
   end

   // ----------------------------------------------------------------
   // Shared clock synchroniser
   // ----------------------------------------------------------------
   logic shared_meta;
   logic shared_sync;

   // Reset high so a pin held high at start gives no false edge
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         shared_meta <= `DSR_CLOCK_SYNC_RESET;
         shared_sync <= `DSR_CLOCK_SYNC_RESET;
      end else begin
         shared_meta <= shared_shift_clock_i;
         shared_sync <= shared_meta;
      end
   end

   // ----------------------------------------------------------------
   // Per register front end and chain
   // ----------------------------------------------------------------
   for (genvar g = 0; g < CHAINS; g++) begin : g_chain
      logic own_meta;
      logic own_sync;
      logic sel_meta;
      logic sel_sync;
      logic src_a_meta;
      logic src_a_sync;
      logic src_b_meta;
      logic src_b_sync;
      logic comb_clock;
      logic comb_prev;
      logic data_hold;
      logic next_data_hold;
      dsr_src_t src_pick;
      dsr_chain_if link ();

      // ------------------------------------------------------------
      // Pin synchronisers
      // ------------------------------------------------------------
      // Own clock synchroniser, same depth as the shared one
      always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
         if (!reset_n_i) begin
            own_meta <= `DSR_CLOCK_SYNC_RESET;
            own_sync <= `DSR_CLOCK_SYNC_RESET;
         end else begin
            own_meta <= shift_clock_i[g];
            own_sync <= own_meta;
         end
      end

      // Select synchroniser, aligned with the clock path
      always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
         if (!reset_n_i) begin
            sel_meta <= `DSR_DATA_SYNC_RESET;
            sel_sync <= `DSR_DATA_SYNC_RESET;
         end else begin
            sel_meta <= source_select_i[g];
            sel_sync <= sel_meta;
         end
      end

      // Source A synchroniser, same depth as the clocks
      always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
         if (!reset_n_i) begin
            src_a_meta <= `DSR_DATA_SYNC_RESET;
            src_a_sync <= `DSR_DATA_SYNC_RESET;
         end else begin
            src_a_meta <= serial_source_a_i[g];
            src_a_sync <= src_a_meta;
         end
      end

      // Source B synchroniser, same depth as the clocks
      always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
         if (!reset_n_i) begin
            src_b_meta <= `DSR_DATA_SYNC_RESET;
            src_b_sync <= `DSR_DATA_SYNC_RESET;
         end else begin
            src_b_meta <= serial_source_b_i[g];
            src_b_sync <= src_b_meta;
         end
      end

      // ------------------------------------------------------------
      // Combined clock
      // ------------------------------------------------------------
      // Either input high counts as high
      assign comb_clock = own_sync | shared_sync;

      // ------------------------------------------------------------
      // Serial source
      // ------------------------------------------------------------
      // Multiplexer on the synchronised select
      assign src_pick = dsr_src_t'(sel_sync);

      // Source choice; unknown selects fall back to source A
      always_comb begin
         next_data_hold = src_a_sync;
         case (src_pick)
            DSR_SRC_A: begin
               next_data_hold = src_a_sync;
            end
            DSR_SRC_B: begin
               next_data_hold = src_b_sync;
            end
            default: begin
               next_data_hold = src_a_sync;
            end
         endcase
      end

      // Held sample is the value one cycle before the rise is seen
      always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
         if (!reset_n_i) begin
            data_hold <= `DSR_DATA_SYNC_RESET;
         end else begin
            data_hold <= next_data_hold;
         end
      end

      // ------------------------------------------------------------
      // Edge detect
      // ------------------------------------------------------------
      // Edge history; starts high so nothing moves before a real rise
      always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
         if (!reset_n_i) begin
            comb_prev <= `DSR_CLOCK_SYNC_RESET;
         end else begin
            comb_prev <= comb_clock;
         end
      end

      // Only a low-to-high move shifts; high hold and fall do nothing
      assign link.shift_pulse = comb_clock & ~comb_prev;
      assign link.serial_input = data_hold;

      // ------------------------------------------------------------
      // Shift chain and outputs
      // ------------------------------------------------------------
      dsr_shift_chain #(
         .STAGES(STAGES)
      ) u_chain (
         .ref_clk_i(ref_clk_i),
         .clear_n_i(clear_sync_n),
         .link(link)
      );

      // Outputs straight from the chain flops
      assign last_stage_out_o[g] = link.last_stage_out;
      assign last_stage_out_n_o[g] = link.last_stage_out_n;
   end

endmodule

`default_nettype wire

/* File: verif/dsr_dual_shift_assertions.sv */
`timescale 1ns/100ps
`default_nettype none

module dsr_dual_shift_checker #(
   parameter int CHAINS = 2,
   parameter int STAGES = 8
) (
   input wire logic ref_clk_i, // Clock
   input wire logic reset_n_i, // Reset
   input wire logic clear_all_n_i, // Clear pin
   input wire logic shared_shift_clock_i, // Shared clock pin
   input wire logic [CHAINS-1:0] shift_clock_i, // Own clocks
   input wire logic [CHAINS-1:0] source_select_i, // Selects
   input wire logic [CHAINS-1:0] serial_source_a_i, // Source A
   input wire logic [CHAINS-1:0] serial_source_b_i, // Source B
   input wire logic [CHAINS-1:0] last_stage_out_o, // True out
   input wire logic [CHAINS-1:0] last_stage_out_n_o // Inverted out
);
   // ----------
   // Combined clock history
   // ----------
   logic [CHAINS-1:0] comb, h0, h1, h2, h3;
   assign comb = shift_clock_i | {CHAINS{shared_shift_clock_i}};
   // Resets high like the clock synchronisers, so release is never an edge
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         {h3, h2, h1, h0} <= '1;
      end else begin
         {h3, h2, h1, h0} <= {h2, h1, h0, comb};
      end
   end

   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!reset_n_i);
   sequence s_held(int k);
      (comb[k] && clear_all_n_i)[*5];
   endsequence
   sequence s_quiet(int k);
      (!comb[k] && clear_all_n_i)[*5];
   endsequence
   property p_inv;
      last_stage_out_n_o == ~last_stage_out_o;
   endproperty
   property p_clear;
      !clear_all_n_i |-> last_stage_out_o == '0 && last_stage_out_n_o == '1;
   endproperty
   property p_hold(int k);
      s_held(k) |-> $stable(last_stage_out_o[k]);
   endproperty
   property p_quiet(int k);
      s_quiet(k) |-> $stable(last_stage_out_o[k]);
   endproperty
   // A change needs a rise seen three edges back
   property p_cause(int k);
      $changed(last_stage_out_o[k]) && clear_all_n_i |-> h2[k] && !h3[k];
   endproperty
   a_inv: assert property (p_inv) else $error("outputs not inverse");
   a_clear: assert property (p_clear) else $error("clear ignored");
   a_hold0: assert property (p_hold(0)) else $error("chain 0 moved while high");
   a_hold1: assert property (p_hold(1)) else $error("chain 1 moved while high");
   a_quiet0: assert property (p_quiet(0)) else $error("chain 0 moved idle");
   a_quiet1: assert property (p_quiet(1)) else $error("chain 1 moved idle");
   a_cause0: assert property (p_cause(0)) else $error("chain 0 bad shift");
   a_cause1: assert property (p_cause(1)) else $error("chain 1 bad shift");
endmodule

bind dsr_dual_shift_top dsr_dual_shift_checker #(.CHAINS(CHAINS), .STAGES(STAGES)) chk_u (
   .ref_clk_i(ref_clk_i),
   .reset_n_i(reset_n_i),
   .clear_all_n_i(clear_all_n_i),
   .shared_shift_clock_i(shared_shift_clock_i),
   .shift_clock_i(shift_clock_i),
   .source_select_i(source_select_i),
   .serial_source_a_i(serial_source_a_i),
   .serial_source_b_i(serial_source_b_i),
   .last_stage_out_o(last_stage_out_o),
   .last_stage_out_n_o(last_stage_out_n_o)
);

`default_nettype wire

/* File: verif/dsr_upstream_model.sv */
`timescale 1ns/100ps
`default_nettype none

module dsr_upstream_model (
   input wire logic ref_clk_i, // Bench clock
   output logic shared_o, // Shared clock pin
   output logic [1:0] own_o, // Own clock pins
   output logic [5:0] data_o // Select, source A, source B
);
   // Idle pins low at start
   initial begin
      {shared_o, own_o, data_o} = '0;
   end

   // One step: inhibit rise with d1, then a pulse with d2
   task automatic step(input logic [1:0] own, input logic sh, input logic [1:0] inh,
                       input logic [5:0] d1, input logic [5:0] d2);
      data_o = d1;
      repeat (2) @(negedge ref_clk_i);
      own_o = inh;
      repeat (3) @(negedge ref_clk_i);
      data_o = d2;
      repeat (2) @(negedge ref_clk_i);
      own_o = inh | own;
      shared_o = sh;
      repeat (3) @(negedge ref_clk_i);
      data_o = ~d2; // Hold over, so lines no longer show the value
      @(negedge ref_clk_i);
      own_o = inh;
      shared_o = 1'h0;
      repeat (3) @(negedge ref_clk_i);
      own_o = 2'h0;
      repeat (4) @(negedge ref_clk_i);
   endtask
endmodule

`default_nettype wire

/* File: verif/testbench.sv */
`timescale 1ns/100ps
`default_nettype none

module testbench;
   logic clk, rst_n, clr_n, sh;
   logic [1:0] own, q, qn, inh;
   logic [5:0] dat;
   logic [7:0] model [2];
   logic [3:0] exp_q [$];
   logic [3:0] e;
   logic [15:0] seed, r;
   int n_mismatch, samples_checked;
   event chk_ev;

   dsr_dual_shift_top dut_u (
      .ref_clk_i(clk), .reset_n_i(rst_n), .clear_all_n_i(clr_n),
      .shared_shift_clock_i(sh), .shift_clock_i(own), .source_select_i(dat[5:4]),
      .serial_source_a_i(dat[3:2]), .serial_source_b_i(dat[1:0]),
      .last_stage_out_o(q), .last_stage_out_n_o(qn));
   dsr_upstream_model up_u (.ref_clk_i(clk), .shared_o(sh), .own_o(own), .data_o(dat));

   function automatic logic [15:0] lfsr(input logic [15:0] x);
      return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
   endfunction

   // Reference shift: stage 0 takes the selected source
   task automatic ref_shift(input int k, input logic [5:0] d);
      model[k] = {model[k][6:0], d[4+k] ? d[k] : d[2+k]};
   endtask

   task automatic note();
      exp_q.push_back({~model[1][7], ~model[0][7], model[1][7], model[0][7]});
      ->chk_ev;
   endtask

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   initial begin
      clk = 1'h0;
      forever #5 clk = ~clk;
   end

   // Monitor: oldest note against the pins
   always @(chk_ev) begin
      e = exp_q.pop_front();
      samples_checked++;
      if ({qn, q} !== e) begin
         n_mismatch++;
         $display("MISMATCH t=%0t got %h exp %h", $time, {qn, q}, e);
      end
   end

   initial begin
      {rst_n, clr_n} = 2'h1;
      seed = 16'h92A2;
      model[0] = 8'h00;
      model[1] = 8'h00;
      repeat (5) @(negedge clk);
      rst_n = 1'h1;
      repeat (3) @(negedge clk);
      note();
      $display("test reset done");
      for (int i = 0; i < 60; i++) begin
         if (i == 30) begin
            clr_n = 1'h0;
            #1;
            model[0] = 8'h00;
            model[1] = 8'h00;
            note();
            repeat (4) @(negedge clk);
            clr_n = 1'h1;
            repeat (4) @(negedge clk);
            $display("test clear done");
         end
         r = lfsr(seed);
         seed = lfsr(r);
         inh = r[15] ? {r[14], ~r[14]} : 2'h0;
         up_u.step(r[13:12], r[11], inh, r[5:0], seed[5:0]);
         for (int k = 0; k < 2; k++) begin
            if (inh[k])
               ref_shift(k, r[5:0]);
            else if (r[12+k] | r[11])
               ref_shift(k, seed[5:0]);
         end
         note();
      end
      repeat (2) @(negedge clk); // Let the monitor take the last note
      $display("test random shifts done");
      tally_and_finish();
   end
endmodule

`default_nettype wire
